// ### hdl/status_change_pkg.sv
// Contract
// - one change latch catches 1-to-0 state edges, the other 0-to-1 edges.
// - change latches clear at power-on, on being read and on clear-status.
// - a set mask bit whose change bit is captured sets the summary bit to 1.
// - with both masks all zero the summary bit never becomes 1.
// - both masks are zero after power-up, then hold what software writes.
// - state, latches and masks share one 16-bit layout; unused bits read 0.
// - low byte: high voltage 7, magnitude change 6, temp cal 5, operating 0.
// - report-printing reads 1 while a calibration report is being printed.
// - the output-stable bit is 1 once the output has output_stable within accuracy.
// - remote-control is 1 while the instrument is under remote control.
// - high-voltage is 1 while the programmed voltage is above 33 Volts.
// - magnitude change is 0 in the state word and sets the latches and the capture irq bits.
// - temporary-cal is 1 while unstored calibration constants are in use.
package status_change_pkg;

    // -----------------------------------------------------------------
    // register map (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [7:0] OFS_STATE        = 8'h00;
    localparam logic [7:0] OFS_FALL_LATCH   = 8'h04;
    localparam logic [7:0] OFS_RISE_LATCH   = 8'h08;
    localparam logic [7:0] OFS_FALL_MASK    = 8'h0c;
    localparam logic [7:0] OFS_RISE_MASK    = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS   = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK     = 8'h18;

    // -----------------------------------------------------------------
    // field positions of the shared 16-bit layout
    // -----------------------------------------------------------------
    localparam int BIT_REPORT_PRINTING = 12;
    localparam int BIT_OUTPUT_STABLE   = 11;
    localparam int BIT_REMOTE_CONTROL  = 10;
    localparam int BIT_HIGH_VOLTAGE    = 7;
    localparam int BIT_MAGNITUDE_CHG   = 6;
    localparam int BIT_TEMPORARY_CAL   = 5;
    localparam int BIT_OUTPUT_OUTPUT_OPERATING     = 0;

    // interrupt status bits
    localparam int IRQ_FALL_CAPTURE = 0;
    localparam int IRQ_RISE_CAPTURE = 1;
    localparam int IRQ_SUMMARY_RISE = 2;

    // -----------------------------------------------------------------
    // reset values and limits
    // -----------------------------------------------------------------
    localparam logic [15:0] RESET_WORD        = 16'h0000;
    localparam logic [2:0]  RESET_IRQ         = 3'h0;
    localparam logic [19:0] HIGH_VOLT_LIMIT_MV = 20'h080e8; // 33000 mV
    localparam logic [15:0] LAYOUT_MASK       = 16'h1ce1; // bits in use

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        report_printing;
        logic        output_stable;
        logic        remote_control;
        logic [19:0] programmed_mv;
        logic        magnitude_changed;
        logic        temporary_cal_in_use;
        logic        output_operating;
    } state_src_t;

endpackage

// ### hdl/instrument_status_change_regs.sv
`timescale 1ns/1ps
module instrument_status_change_regs (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire status_change_pkg::apb_req_t   apb_req,
    output logic                               pready,
    output logic [31:0]                        prdata,
    output logic                               pslverr,
    input  wire status_change_pkg::state_src_t state_src,
    input  wire logic                          clear_status,
    output logic                               change_summary_bit,
    output logic                               irq
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [15:0] instrument_state;
    logic [15:0] falling_change_latch;
    logic [15:0] rising_change_latch;
    logic [15:0] falling_change_mask;
    logic [15:0] rising_change_mask;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;

    // -----------------------------------------------------------------
    // live state word from the instrument
    // -----------------------------------------------------------------
    logic [15:0] live_state;
    logic        above_limit;

    assign above_limit = state_src.programmed_mv
                         > status_change_pkg::HIGH_VOLT_LIMIT_MV;

    // build the word; bits not named stay zero
    always_comb begin
        live_state = status_change_pkg::RESET_WORD;
        live_state[status_change_pkg::BIT_REPORT_PRINTING] =
            state_src.report_printing;
        live_state[status_change_pkg::BIT_OUTPUT_STABLE] =
            state_src.output_stable;
        live_state[status_change_pkg::BIT_REMOTE_CONTROL] =
            state_src.remote_control;
        live_state[status_change_pkg::BIT_HIGH_VOLTAGE] =
            above_limit;
        live_state[status_change_pkg::BIT_TEMPORARY_CAL] =
            state_src.temporary_cal_in_use;
        live_state[status_change_pkg::BIT_OUTPUT_OUTPUT_OPERATING] =
            state_src.output_operating;
        // magnitude change stays 0 here
    end

    // -----------------------------------------------------------------
    // edge capture
    // -----------------------------------------------------------------
    logic [15:0] mag_word;
    logic [15:0] fall_edges;
    logic [15:0] rise_edges;

    // magnitude change reaches the change latches and irq capture bits, not the state word
    assign mag_word = {9'h000, state_src.magnitude_changed, 6'h00};
    assign fall_edges = (instrument_state & ~live_state) | mag_word;
    assign rise_edges = (~instrument_state & live_state) | mag_word;

    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    logic setup_phase;
    logic access_done;
    logic wr_done;
    logic rd_done;
    logic hit_state;
    logic hit_fall_latch;
    logic hit_rise_latch;
    logic hit_fall_mask;
    logic hit_rise_mask;
    logic hit_irq_status;
    logic hit_irq_mask;
    logic hit_any;

    assign setup_phase    = apb_req.psel & ~apb_req.penable;
    assign access_done    = apb_req.psel & apb_req.penable & pready;
    assign wr_done        = access_done & apb_req.pwrite;
    assign rd_done        = access_done & ~apb_req.pwrite;
    assign hit_state      = apb_req.paddr == status_change_pkg::OFS_STATE;
    assign hit_fall_latch = apb_req.paddr == status_change_pkg::OFS_FALL_LATCH;
    assign hit_rise_latch = apb_req.paddr == status_change_pkg::OFS_RISE_LATCH;
    assign hit_fall_mask  = apb_req.paddr == status_change_pkg::OFS_FALL_MASK;
    assign hit_rise_mask  = apb_req.paddr == status_change_pkg::OFS_RISE_MASK;
    assign hit_irq_status = apb_req.paddr == status_change_pkg::OFS_IRQ_STATUS;
    assign hit_irq_mask   = apb_req.paddr == status_change_pkg::OFS_IRQ_MASK;
    assign hit_any = hit_state | hit_fall_latch | hit_rise_latch
                   | hit_fall_mask | hit_rise_mask | hit_irq_status
                   | hit_irq_mask;

    // read mux, sampled in the setup cycle
    logic [31:0] read_word;

    assign read_word =
          hit_state      ? {16'h0000, instrument_state}
        : hit_fall_latch ? {16'h0000, falling_change_latch}
        : hit_rise_latch ? {16'h0000, rising_change_latch}
        : hit_fall_mask  ? {16'h0000, falling_change_mask}
        : hit_rise_mask  ? {16'h0000, rising_change_mask}
        : hit_irq_status ? {29'h0, irq_status}
        : hit_irq_mask   ? {29'h0, irq_mask}
        : 32'h0000_0000;

    // -----------------------------------------------------------------
    // next values
    // -----------------------------------------------------------------
    logic [15:0] keep_fall;
    logic [15:0] keep_rise;
    logic [2:0]  keep_irq;
    logic [15:0] next_falling_change_latch;
    logic [15:0] next_rising_change_latch;
    logic [15:0] next_falling_change_mask;
    logic [15:0] next_rising_change_mask;
    logic        next_summary;
    logic [2:0]  irq_events;
    logic [2:0]  next_irq_status;
    logic [2:0]  next_irq_mask;

    // a read clears only the bits it reported, so an edge caught after
    // the read data was taken waits for the next read
    assign keep_fall = clear_status ? status_change_pkg::RESET_WORD
        : (rd_done & hit_fall_latch) ? falling_change_latch & ~prdata[15:0]
        : falling_change_latch;
    assign keep_rise = clear_status ? status_change_pkg::RESET_WORD
        : (rd_done & hit_rise_latch) ? rising_change_latch & ~prdata[15:0]
        : rising_change_latch;

    // a new edge in the clearing cycle is kept
    assign next_falling_change_latch = keep_fall | fall_edges;
    assign next_rising_change_latch  = keep_rise | rise_edges;

    // only layout bits are stored, the rest read back as zero
    assign next_falling_change_mask = (wr_done & hit_fall_mask)
        ? apb_req.pwdata[15:0] & status_change_pkg::LAYOUT_MASK
        : falling_change_mask;
    assign next_rising_change_mask = (wr_done & hit_rise_mask)
        ? apb_req.pwdata[15:0] & status_change_pkg::LAYOUT_MASK
        : rising_change_mask;

    // summary follows the latch and mask values it will hold
    assign next_summary =
        |((next_falling_change_latch & next_falling_change_mask)
        | (next_rising_change_latch & next_rising_change_mask));

    assign irq_events = {next_summary & ~change_summary_bit,
                         |rise_edges, |fall_edges};

    // read clears, a same-cycle event wins
    assign keep_irq = (rd_done & hit_irq_status)
        ? irq_status & ~prdata[2:0] : irq_status;
    assign next_irq_status = keep_irq | irq_events;
    assign next_irq_mask = (wr_done & hit_irq_mask)
        ? apb_req.pwdata[2:0] : irq_mask;

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------

    // state word and change latches
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            instrument_state     <= status_change_pkg::RESET_WORD;
            falling_change_latch <= status_change_pkg::RESET_WORD;
            rising_change_latch  <= status_change_pkg::RESET_WORD;
        end else begin
            instrument_state     <= live_state;
            falling_change_latch <= next_falling_change_latch;
            rising_change_latch  <= next_rising_change_latch;
        end
    end

    // masks and summary
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            falling_change_mask <= status_change_pkg::RESET_WORD;
            rising_change_mask  <= status_change_pkg::RESET_WORD;
            change_summary_bit  <= 1'b0;
        end else begin
            falling_change_mask <= next_falling_change_mask;
            rising_change_mask  <= next_rising_change_mask;
            change_summary_bit  <= next_summary;
        end
    end

    // interrupt status, mask and line
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_status <= status_change_pkg::RESET_IRQ;
            irq_mask   <= status_change_pkg::RESET_IRQ;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
            irq        <= |(next_irq_status & next_irq_mask);
        end
    end

    // apb answer: one wait-free access phase after each setup
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_phase;
            prdata  <= setup_phase ? read_word : 32'h0000_0000;
            pslverr <= setup_phase & ~hit_any;
        end
    end

endmodule

// ### tb/status_change_properties.sv
`timescale 1ns/1ps
module status_change_properties (
    input wire logic                          mclk,
    input wire logic                          rst,
    input wire status_change_pkg::apb_req_t   apb_req,
    input wire logic                          pready,
    input wire logic [31:0]                   prdata,
    input wire logic                          pslverr,
    input wire status_change_pkg::state_src_t state_src,
    input wire logic                          clear_status,
    input wire logic                          change_summary_bit,
    input wire logic                          irq
);
    // ----------------------------------------------------------------
    // bus answer timing and read layout
    // ----------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // setup cycle seen by the slave
    wire setup = apb_req.psel && !apb_req.penable;
    wire low_map = apb_req.paddr < 8'h14;
    setup_ready_a: assert property (setup |=> pready)
        else $error("no ready after setup");
    ready_cause_a: assert property (pready |-> $past(setup))
        else $error("ready without setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper read bits set");
    gap_zero_a: assert property (pready && low_map |->
        {prdata[15:13], prdata[9:8], prdata[4:1]} == 9'h0)
        else $error("unused layout bit set");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer malformed");
    mag_state_a: assert property (pready &&
        apb_req.paddr == status_change_pkg::OFS_STATE |-> !prdata[6])
        else $error("magnitude bit set in state");
    cover property (pready && apb_req.pwrite);
    cover property ($rose(change_summary_bit));
    cover property ($rose(irq));
endmodule
bind instrument_status_change_regs status_change_properties chk_i (
    .mclk(mclk), .rst(rst), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .state_src(state_src),
    .clear_status(clear_status),
    .change_summary_bit(change_summary_bit), .irq(irq));

// ### tb/remote_ctrl_model.sv
`timescale 1ns/1ps
module remote_ctrl_model (
    input  wire logic                   mclk,
    input  wire logic                   pready,
    input  wire logic [31:0]            prdata,
    input  wire logic                   pslverr,
    output status_change_pkg::apb_req_t apb_req
);
    initial apb_req = '0;
    // one apb transfer: setup, access held until pready, then release
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd,
        output logic err, output logic tmo);
        int n;
        @(posedge mclk);
        apb_req <= '{1'b1, 1'b0, w, a, wd};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        tmo = (n >= 50);
        apb_req <= '0;
    endtask
endmodule

// ### tb/instrument_status_change_regs_tb.sv
`timescale 1ns/1ps
module instrument_status_change_regs_tb;
    logic                          mclk = 1'b0;
    logic                          rst = 1'b1;
    logic                          clear_status = 1'b0;
    status_change_pkg::apb_req_t   apb_req;
    status_change_pkg::state_src_t src = '0;
    logic                          pready, pslverr, csb, irq, err, tmo;
    logic [31:0]                   prdata, rd;
    int                            n_errors = 0;
    int                            check_count = 0;
    // ----------------------------------------------------------------
    // clock, design and controller model
    // ----------------------------------------------------------------
    always #12.5 mclk = ~mclk;
    instrument_status_change_regs instrument_status_change_regs_i (
        .mclk(mclk), .rst(rst), .apb_req(apb_req), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .state_src(src),
        .clear_status(clear_status), .change_summary_bit(csb),
        .irq(irq));
    remote_ctrl_model remote_ctrl_model_i (.mclk(mclk), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .apb_req(apb_req));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic acc(logic w, logic [7:0] a, logic [31:0] wd);
        remote_ctrl_model_i.xfer(w, a, wd, rd, err, tmo);
        if (tmo) begin
            n_errors++;
            wrap_up();
        end
    endtask
    task automatic rd_chk(logic [7:0] a, logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        check("read", rd, exp);
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) rd_chk(8'(4 * i), 32'h0);
        acc(1'b0, 8'h1c, 32'h0);
        check("unmapped", {31'h0, err}, 32'h1);
        acc(1'b1, status_change_pkg::OFS_FALL_MASK, 32'hffffffff);
        rd_chk(status_change_pkg::OFS_FALL_MASK, 32'h1ce1);
        acc(1'b1, status_change_pkg::OFS_FALL_MASK, 32'h0);
        src <= '{1'b1, 1'b1, 1'b1, 20'd33001, 1'b0, 1'b1, 1'b1};
        tick(3);
        check("summary", {31'h0, csb}, 32'h0);
        rd_chk(status_change_pkg::OFS_STATE, 32'h1ca1);
        rd_chk(status_change_pkg::OFS_RISE_LATCH, 32'h1ca1);
        rd_chk(status_change_pkg::OFS_RISE_LATCH, 32'h0);
        src.programmed_mv <= 20'd33000;
        rd_chk(status_change_pkg::OFS_STATE, 32'h1c21);
        rd_chk(status_change_pkg::OFS_FALL_LATCH, 32'h0080);
        acc(1'b1, status_change_pkg::OFS_FALL_MASK, 32'h1);
        src.output_operating <= 1'b0;
        tick(3);
        check("summary", {31'h0, csb}, 32'h1);
        @(posedge mclk);
        clear_status <= 1'b1;
        @(posedge mclk);
        clear_status <= 1'b0;
        tick(3);
        check("summary", {31'h0, csb}, 32'h0);
        rd_chk(status_change_pkg::OFS_FALL_LATCH, 32'h0);
        src.magnitude_changed <= 1'b1;
        @(posedge mclk);
        src.magnitude_changed <= 1'b0;
        rd_chk(status_change_pkg::OFS_STATE, 32'h1c20);
        rd_chk(status_change_pkg::OFS_RISE_LATCH, 32'h0040);
        rd_chk(status_change_pkg::OFS_FALL_LATCH, 32'h0040);
        acc(1'b1, status_change_pkg::OFS_RISE_MASK, 32'hffffffff);
        rd_chk(status_change_pkg::OFS_RISE_MASK, 32'h1ce1);
        src.output_operating <= 1'b1;
        tick(3);
        check("summary", {31'h0, csb}, 32'h1);
        rd_chk(status_change_pkg::OFS_RISE_LATCH, 32'h0001);
        tick(1);
        check("summary", {31'h0, csb}, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
        acc(1'b1, status_change_pkg::OFS_IRQ_MASK, 32'h7);
        tick(2);
        check("irq", {31'h0, irq}, 32'h1);
        rd_chk(status_change_pkg::OFS_IRQ_STATUS, 32'h7);
        tick(2);
        check("irq", {31'h0, irq}, 32'h0);
        wrap_up();
    end
endmodule
